// [include/opto_debounce_pkg.sv]
package opto_debounce_pkg;

    // One input's debounce configuration as software left it
    typedef struct packed {
        logic ac_mode;
        logic [6:0] hundredths;
    } debounce_setting_s;

    // Quantised timer targets handed to one input timer
    typedef struct packed {
        logic ac_mode;
        logic [4:0] sixteenths;
    } timer_cfg_s;

endpackage

// [include/opto_debounce_regs.svh]
`ifndef OPTO_DEBOUNCE_REGS_SVH
`define OPTO_DEBOUNCE_REGS_SVH

// Core clock and power-system timing
`define OPTO_CLK_PERIOD_NS 100
`define OPTO_SYS_FREQ_HZ 60
`define OPTO_NS_PER_S 1000000000
`define OPTO_SLICES_PER_CYCLE 16
// Clock cycles per sixteenth of a power-system cycle, rounded down
`define OPTO_TICK_CYCLES (`OPTO_NS_PER_S / (`OPTO_CLK_PERIOD_NS * `OPTO_SYS_FREQ_HZ * `OPTO_SLICES_PER_CYCLE))

// Sixteenth ticks per quarter-cycle processing interval, last index
`define OPTO_LAST_SLICE 2'h3

// Register byte offsets
`define OPTO_SET_BASE_OFS 8'h00
`define OPTO_BITS_OFS 8'h18
`define OPTO_RAW_OFS 8'h1c
`define OPTO_TIMER_OFS 8'h20

// Setting register fields
`define OPTO_SET_LSB 0
`define OPTO_SET_MSB 6
`define OPTO_AC_BIT 8
`define OPTO_SET_RESET 7'h32
`define OPTO_SET_MAX 7'h64
`define OPTO_ROUND_HALF 12'h032
`define OPTO_ROUND_DIV 12'h064

// AC mode timer targets in sixteenth ticks
`define OPTO_AC_PICKUP 5'h01
`define OPTO_AC_DROPOUT 5'h10

`endif

// [logic/debounce_timer.sv]
`timescale 1ns/1ps
`include "opto_debounce_regs.svh"

// Combined pickup/dropout timer for one optoisolated input
module debounce_timer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic raw,
    input wire opto_debounce_pkg::timer_cfg_s cfg,
    output logic state
);
    logic state_q;
    logic state_d;
    logic [4:0] count_q;
    logic [4:0] count_d;
    logic [4:0] target;
    logic [4:0] count_inc;
    wire differs = raw != state_q;
    wire done;

    // AC mode picks up fast and drops out slowly so ripple zeros are bridged
    assign target = cfg.ac_mode ? (raw ? `OPTO_AC_PICKUP : `OPTO_AC_DROPOUT)
                                : cfg.sixteenths; // [R1]
    assign count_inc = count_q + 5'h01;
    assign done = (target == 5'h00) || (tick && count_inc >= target); // [R4] [R5]

    // Count only while raw disagrees; agreement restarts the delay
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        if (!differs) begin
            count_d = 5'h00; // [R11]
        end else if (done) begin
            state_d = raw; // [R8] [R11]
            count_d = 5'h00;
        end else if (tick) begin
            count_d = count_inc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= 1'b0;
            count_q <= 5'h00;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    assign state = state_q;
endmodule

// [logic/opto_input_debounce.sv]
`timescale 1ns/1ps
`include "opto_debounce_regs.svh"

// How it works
// [R1] One setting per input sets both pickup and dropout delay; six timers.
// [R2] Setting accepted from 0.00 to 1.00 cycle, or AC mode instead.
// [R3] Setting rounds to the nearest sixteenth cycle; 0.80 runs as 13/16.
// [R4] Every timer advances once per sixteenth-cycle tick.
// [R5] AC mode: pickup within 0.75 cycle, dropout within 1.25 cycles.
// [R6] Debounced bits refresh only once per quarter-cycle interval.
// [R7] Users should pick quarter-cycle steps; default is half a cycle.
// [R8] Energized input reads one, deenergized zero, after the debounce time.
// [R9] Inputs have no fixed function; any logic may read each bit.
// [R10] Debounce beyond one cycle belongs in a separate downstream timer.
// [R11] Raw return to current state restarts count; zero setting passes through.
module opto_input_debounce #(
    parameter int NUM_INPUTS = 6,
    parameter int TICK_CYCLES = `OPTO_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NUM_INPUTS-1:0] opto_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [NUM_INPUTS-1:0] debounced_input_bit,
    output logic interval_strobe
);

    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

    // Rounds hundredths of a cycle to the nearest sixteenth
    function automatic logic [4:0] round_sixteenths(input logic [6:0] hundredths);
        logic [11:0] scaled;
        scaled = {1'b0, hundredths, 4'h0} + `OPTO_ROUND_HALF;
        return 5'(scaled / `OPTO_ROUND_DIV); // [R3]
    endfunction

    // Clamps an entry to the permitted range of one cycle
    function automatic logic [6:0] clamp_setting(input logic [6:0] hundredths);
        return (hundredths > `OPTO_SET_MAX) ? `OPTO_SET_MAX : hundredths; // [R2]
    endfunction

    // Sixteenth-cycle tick and quarter-cycle processing interval

    logic [DIV_W-1:0] div_q;
    logic [1:0] slice_q;
    logic tick;
    logic interval;

    // The divider is free running so timers and interval stay phase locked
    assign tick = (div_q == DIV_LAST);
    assign interval = tick && (slice_q == `OPTO_LAST_SLICE);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + DIV_W'(1);
        end
    end

    // Four sixteenth ticks make one processing interval
    always_ff @(posedge core_clk) begin
        if (rst) begin
            slice_q <= 2'h0;
        end else if (tick) begin
            slice_q <= slice_q + 2'h1;
        end
    end

    // Wishbone slave

    logic ack_q;
    logic [31:0] rdata_q;
    wire req = wb_cyc_i && wb_stb_i;
    wire req_new = req && !ack_q;
    wire wr_take = req && ack_q && wb_we_i;

    // Address decode
    wire [7:0] set_rel = wb_adr_i - `OPTO_SET_BASE_OFS;
    wire [5:0] set_idx = set_rel[7:2];
    wire hit_set = (set_rel[1:0] == 2'h0) && (set_idx < 6'(NUM_INPUTS));
    wire hit_bits = (wb_adr_i == `OPTO_BITS_OFS);
    wire hit_raw = (wb_adr_i == `OPTO_RAW_OFS);
    wire hit_timer = (wb_adr_i == `OPTO_TIMER_OFS);

    // One wait state: ack follows the request by one edge and drops after it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_new;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Setting registers

    opto_debounce_pkg::debounce_setting_s setting_q [NUM_INPUTS];
    opto_debounce_pkg::timer_cfg_s cfg [NUM_INPUTS];
    logic [NUM_INPUTS-1:0] timer_state;
    logic [NUM_INPUTS-1:0] bits_q;

    // Entry written by software, clamped before it is stored
    opto_debounce_pkg::debounce_setting_s set_wdata;
    assign set_wdata.hundredths = clamp_setting(wb_dat_i[`OPTO_SET_MSB:`OPTO_SET_LSB]);
    assign set_wdata.ac_mode = wb_dat_i[`OPTO_AC_BIT]; // [R2]

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
            wire pick_me = hit_set && (set_idx == 6'(gi));

            // Factory state is half a cycle, not AC; writes land on the ack edge
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    setting_q[gi].hundredths <= `OPTO_SET_RESET; // [R7]
                    setting_q[gi].ac_mode <= 1'b0;
                end else if (wr_take && pick_me) begin
                    if (wb_sel_i[0]) begin
                        setting_q[gi].hundredths <= set_wdata.hundredths;
                    end
                    if (wb_sel_i[1]) begin
                        setting_q[gi].ac_mode <= set_wdata.ac_mode;
                    end
                end
            end

            // Quantisation is held here so the timer sees sixteenths only
            assign cfg[gi].sixteenths = round_sixteenths(setting_q[gi].hundredths); // [R3]
            assign cfg[gi].ac_mode = setting_q[gi].ac_mode; // [R5]

            // Independent timer per input
            debounce_timer u_timer (
                .core_clk(core_clk),
                .rst(rst),
                .tick(tick),
                .raw(opto_in[gi]),
                .cfg(cfg[gi]),
                .state(timer_state[gi])
            ); // [R1] [R4]
        end
    endgenerate

    // Processing-interval image of the inputs

    // A timer that finishes mid interval waits for the next boundary,
    // which keeps every consumer on one coherent snapshot
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bits_q <= '0;
        end else if (interval) begin
            bits_q <= timer_state; // [R6] [R8]
        end
    end

    // Plain bits with unlimited fan-out; no function is bound to them
    assign debounced_input_bit = bits_q; // [R9]
    assign interval_strobe = interval;

    // Read data

    logic [31:0] rdata_mux;
    opto_debounce_pkg::debounce_setting_s set_rd;
    assign set_rd = hit_set ? setting_q[set_idx[2:0]] : '0;

    // Unmapped offsets read as zero and ignore writes, still acked
    always_comb begin
        rdata_mux = 32'h0000_0000;
        if (hit_set) begin
            rdata_mux[`OPTO_SET_MSB:`OPTO_SET_LSB] = set_rd.hundredths;
            rdata_mux[`OPTO_AC_BIT] = set_rd.ac_mode;
        end else if (hit_bits) begin
            rdata_mux[NUM_INPUTS-1:0] = bits_q;
        end else if (hit_raw) begin
            rdata_mux[NUM_INPUTS-1:0] = opto_in;
        end else if (hit_timer) begin
            rdata_mux[NUM_INPUTS-1:0] = timer_state;
        end
    end

    // Data is captured with the request so it is stable when ack rises
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (req_new) begin
            rdata_q <= rdata_mux;
        end
    end

endmodule

// [testbench/field_contacts.sv]
`timescale 1ns/1ps
module field_contacts (
    input wire logic core_clk,
    input wire logic [5:0] closed,
    input wire logic [5:0] chatter,
    output logic [5:0] opto_in
);
    logic bounce_q = 1'b0;
    // A bouncing contact flips every clock, so it never settles long enough for a timer whose target is two or more sixteenths
    always_ff @(posedge core_clk) bounce_q <= !bounce_q;
    assign opto_in = closed ^ (chatter & {6{bounce_q}});
endmodule

// [testbench/opto_debounce_checker.sv]
`timescale 1ns/1ps
module opto_debounce_checker #(
    parameter int NUM_INPUTS = 6,
    parameter int TICK_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NUM_INPUTS-1:0] opto_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NUM_INPUTS-1:0] debounced_input_bit,
    input wire logic interval_strobe
);
    localparam int IV = 4 * TICK_CYCLES;
    localparam int LIM = 24 * TICK_CYCLES;
    logic [NUM_INPUTS-1:0] prev_q;
    logic [15:0] calm_q;
    // Counts clocks with the raw inputs unchanged; saturates so a long calm spell never wraps
    always_ff @(posedge core_clk) begin
        prev_q <= opto_in;
        if (rst || opto_in != prev_q) calm_q <= 16'h0000;
        else if (calm_q != 16'hffff) calm_q <= calm_q + 16'h0001;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h20 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_reset_clears_outputs: assert property (disable iff (1'b0) rst |=> !wb_ack_o && debounced_input_bit == '0)
        else $error("reset did not clear");
    a_bits_hold_between: assert property (!interval_strobe |=> $stable(debounced_input_bit))
        else $error("bits moved off boundary");
    a_strobe_gap_kept: assert property (interval_strobe |=> !interval_strobe [*8])
        else $error("boundary too soon");
    a_strobe_period_exact: assert property (interval_strobe |-> ##IV interval_strobe)
        else $error("boundary period wrong");
    a_bits_settle_raw: assert property (
        calm_q > LIM && interval_strobe |=> debounced_input_bit == $past(opto_in))
        else $error("bits not following steady input");
endmodule

// [testbench/opto_input_debounce_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
    checks_done++; \
    if ((s) !== (e)) begin \
        err_count++; \
        $display("[ERR] %s exp %0h got %0h", n, e, s); \
    end \
end
module opto_input_debounce_tb;
    logic core_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, strobe;
    logic [7:0] adr = 8'h00;
    logic [3:0] byte_en = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o, lfsr = 32'h15e24b4f;
    logic [5:0] closed = 6'h00, chatter = 6'h00, opto_in, bits, exp_bits = 6'h00;
    int err_count = 0, checks_done = 0;
    int vals[8] = '{0, 13, 50, 80, 100, 120, 19, 70};
    initial forever #50 core_clk = ~core_clk;
    field_contacts fc (.core_clk(core_clk), .closed(closed), .chatter(chatter), .opto_in(opto_in));
    opto_input_debounce #(.NUM_INPUTS(6), .TICK_CYCLES(4)) dut (.core_clk(core_clk), .rst(rst), .opto_in(opto_in),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(byte_en), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .debounced_input_bit(bits), .interval_strobe(strobe));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Boundaries seen until the bit follows; a flip on a boundary edge loads one interval later
    function automatic int exp_strobes(input int h);
        return ((h > 100 ? 100 : h) * 16 + 50) / 100 / 4 + 1;
    endfunction
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One classic cycle, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        byte_en <= 4'hf;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (ack === 1'b1) break;
        end
        rdat = dat_o;
        if (k == 20) begin
            err_count++;
            complete_run();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_strobe;
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge core_clk);
            if (strobe === 1'b1) break;
        end
        if (k == 40) begin
            err_count++;
            complete_run();
        end
    endtask
    // Moves one contact two clocks past a boundary, so the first tick after it counts as one
    task automatic edge_run(input int i, input logic v, input int exp_c, input logic ac);
        int c;
        wait_strobe();
        repeat (2) @(posedge core_clk);
        closed[i] <= v;
        exp_bits[i] = v;
        for (c = 1; c < 9; c++) begin
            wait_strobe();
            #1;
            if (bits[i] === v) break;
        end
        if (ac) `CHK("ac_delay", 1'b1, c <= exp_c)
        else `CHK("delay", exp_c, c)
        `CHK("bits", exp_bits, bits)
        @(posedge core_clk);
        // The image, the raw levels and the settled timers as software sees them
        bus(1'b0, 8'h18, 32'h0);
        `CHK("bits_reg", 32'(exp_bits), rdat)
        bus(1'b0, 8'h1c, 32'h0);
        `CHK("raw_reg", 32'(closed), rdat)
        bus(1'b0, 8'h20, 32'h0);
        `CHK("timer_reg", 32'(closed), rdat)
    endtask
    initial begin
        int i, h;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            `CHK("default", 32'h32, rdat)
        end
        bus(1'b1, 8'h40, 32'hff);
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, rdat)
        // Corner settings first, then random ones; out-of-range entries clamp to a full cycle
        for (i = 0; i < 14; i++) begin
            lfsr = lfsr_next(lfsr);
            h = i < 8 ? vals[i] : int'(lfsr[6:0]);
            bus(1'b1, 8'((i % 6) * 4), {24'h0, 8'(h)});
            bus(1'b0, 8'((i % 6) * 4), 32'h0);
            `CHK("setting", h > 100 ? 32'h64 : 32'(h), rdat)
            edge_run(i % 6, 1'b1, exp_strobes(h), 1'b0);
            edge_run(i % 6, 1'b0, exp_strobes(h), 1'b0);
        end
        bus(1'b1, 8'h00, 32'h64);
        chatter <= 6'h01;
        repeat (200) @(posedge core_clk);
        `CHK("chatter", exp_bits, bits)
        chatter <= 6'h00;
        bus(1'b1, 8'h14, 32'h100);
        edge_run(5, 1'b1, 3, 1'b1);
        edge_run(5, 1'b0, 5, 1'b1);
        // A long calm spell so the steady-input check meets at least one boundary
        repeat (150) @(posedge core_clk);
        complete_run();
    end
endmodule
bind opto_input_debounce opto_debounce_checker #(.NUM_INPUTS(NUM_INPUTS), .TICK_CYCLES(TICK_CYCLES)) chk (
    .core_clk(core_clk), .rst(rst), .opto_in(opto_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .debounced_input_bit(debounced_input_bit), .interval_strobe(interval_strobe));
